// file: core/fbp_pkg.sv
// constants and types shared by the framebuffer pixel-format block
package fbp_pkg;
	localparam logic [11:0] FBP_OFS_BPP = 12'h020;
	localparam logic [11:0] FBP_OFS_SWAP = 12'h028;
	localparam logic [11:0] FBP_OFS_ORDER = 12'h02c;
	localparam logic [11:0] FBP_OFS_STRIDE = 12'h030;
	localparam logic [11:0] FBP_OFS_ENABLE = 12'h034;
	localparam logic [11:0] FBP_OFS_BASE = 12'h040;
	localparam logic [11:0] FBP_OFS_WIDTH = 12'h044;
	localparam logic [11:0] FBP_OFS_HEIGHT = 12'h048;
	localparam logic [11:0] FBP_OFS_STATUS = 12'h04c;
	localparam logic [11:0] FBP_OFS_PAL_LO = 12'h400;
	localparam logic [11:0] FBP_OFS_PAL_HI = 12'h7fc;
	localparam logic [31:0] FBP_RST_BPP = 32'h0000_0020;
	localparam logic [31:0] FBP_RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] FBP_RST_WIDTH = 32'h0000_0280;
	localparam logic [31:0] FBP_RST_HEIGHT = 32'h0000_01e0;
	localparam int FBP_PAL_SEL = 23;
	localparam int FBP_RED_LSB = 16;
	localparam int FBP_GRN_LSB = 8;
	localparam int FBP_BLU_LSB = 0;
	localparam logic [1:0] FBP_RESP_OKAY = 2'h0;
	localparam logic [1:0] FBP_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic eof;
		logic eol;
		logic [23:0] rgb;
	} fbp_pix_s;
endpackage : fbp_pkg

// file: core/fbp_fifo.sv
// small synchronous fifo between memory responses and pixel extraction
`timescale 1ns/1ns
module fbp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two, at least 2");

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (clr)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + (AW+1)'(push);
			rd_ptr <= rd_ptr + (AW+1)'(pop);
		end
	end
endmodule : fbp_fifo

// file: core/fbp_top.sv
// framebuffer source fetch, byte swap, pixel unpacking and palette lookup
//
// What this block does
// - byte-swap fetched words when big-endian, except 24bpp
// - packing order matters only at 1/2/4 bpp
// - first pixels come from least significant byte
// - order 0 first pixel low bits, 1 high
// - row starts advance by stride; zero means row length
// - runs only while enabled; reconfigure while disabled
// - 256 palette words at 0x400-0x7fc for 1-8 bpp
// - palette word is red, green, blue; top ignored
// - source fetched and swapped as whole 32-bit words
// - depths 1,2,4,8 palette; 15,16,24,32 direct colour
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module fbp_top
	import fbp_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int DIM_W = 12
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic mem_req_valid,
	output logic [31:0] mem_req_addr,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [31:0] mem_rsp_data,
	output logic pix_valid,
	output fbp_pix_s pix_data,
	input wire logic pix_ready
);
	if (FIFO_DEPTH < 2 || DIM_W < 2 || DIM_W > 16) $error("unsupported fifo depth or dimension width");

	typedef enum logic [1:0] {FBP_F_IDLE, FBP_F_REQ, FBP_F_WAIT} fbp_fetch_e;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction : wmerge

	// storage bits per pixel; 15bpp sits in 16-bit cells, unknown codes fall back to 32
	function automatic logic [5:0] cell_bits(input logic [31:0] code);
		case (code)
			32'h0000_0001: return 6'd1;
			32'h0000_0002: return 6'd2;
			32'h0000_0004: return 6'd4;
			32'h0000_0008: return 6'd8;
			32'h0000_000f, 32'h0000_0010: return 6'd16;
			32'h0000_0018: return 6'd24;
			default: return 6'd32;
		endcase
	endfunction : cell_bits

	// reverse pixel groups within each byte so the first pixel always sits lowest
	function automatic logic [31:0] reorder(input logic [31:0] w, input logic [5:0] bits);
		logic [31:0] r;
		r = w;
		for (int b = 0; b < 4; b++)
			for (int k = 0; k < 8; k++)
				case (bits)
					6'd1: r[b*8+k] = w[b*8+7-k];
					6'd2: r[b*8+k] = w[b*8+(6-2*(k/2))+(k%2)];
					6'd4: r[b*8+k] = w[b*8+(k+4)%8];
					default: r[b*8+k] = w[b*8+k];
				endcase
		return r;
	endfunction : reorder

	logic [31:0] reg_bpp;
	logic [31:0] reg_swap;
	logic [31:0] reg_order;
	logic [31:0] reg_stride;
	logic [31:0] reg_enable;
	logic [31:0] reg_base;
	logic [31:0] reg_width;
	logic [31:0] reg_height;
	logic [31:0] palette [256];

	// bus slave: address and data are held separately, write happens once both are in
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_wr = aw_held && w_held && !s_axi_bvalid;
	wire next_aw_held = (aw_held || aw_take) && !do_wr;
	wire next_w_held = (w_held || w_take) && !do_wr;
	wire next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
	wire wr_pal = aw_addr[11:10] == 2'b01;
	wire rd_pal = s_axi_araddr[11:10] == 2'b01;
	wire [7:0] wr_idx = aw_addr[9:2];
	wire enabled = reg_enable[0];

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [31:0] fifo_out_data;
	wire fifo_out_ready;
	logic [DIM_W-1:0] fetch_row;
	fbp_fetch_e fetch_state;

	logic [31:0] rd_val;
	logic rd_ok;
	always_comb
	begin
		rd_ok = 1'b1;
		rd_val = FBP_RST_ZERO;
		if (rd_pal)
			rd_val = palette[s_axi_araddr[9:2]];
		else
			case (s_axi_araddr)
				FBP_OFS_BPP: rd_val = reg_bpp;
				FBP_OFS_SWAP: rd_val = reg_swap;
				FBP_OFS_ORDER: rd_val = reg_order;
				FBP_OFS_STRIDE: rd_val = reg_stride;
				FBP_OFS_ENABLE: rd_val = reg_enable;
				FBP_OFS_BASE: rd_val = reg_base;
				FBP_OFS_WIDTH: rd_val = reg_width;
				FBP_OFS_HEIGHT: rd_val = reg_height;
				FBP_OFS_STATUS: rd_val = {16'h0000, 16'(fetch_row) << 1 | 16'(fetch_state != FBP_F_IDLE)};
				default: rd_ok = 1'b0;
			endcase
	end

	wire wr_known = wr_pal || aw_addr == FBP_OFS_BPP || aw_addr == FBP_OFS_SWAP || aw_addr == FBP_OFS_ORDER
		|| aw_addr == FBP_OFS_STRIDE || aw_addr == FBP_OFS_ENABLE || aw_addr == FBP_OFS_BASE
		|| aw_addr == FBP_OFS_WIDTH || aw_addr == FBP_OFS_HEIGHT || aw_addr == FBP_OFS_STATUS;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= FBP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= FBP_RESP_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (aw_take)
				aw_addr <= {s_axi_awaddr[11:2], 2'b00};
			if (w_take)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready <= !next_w_held && !next_bvalid;
			s_axi_bvalid <= next_bvalid;
			if (do_wr)
				s_axi_bresp <= wr_known ? FBP_RESP_OKAY : FBP_RESP_SLVERR;
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (ar_take)
			begin
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? FBP_RESP_OKAY : FBP_RESP_SLVERR;
			end
		end
	end

	// palette is plain storage with no reset; software loads it before enabling
	always_ff @(posedge sys_clk)
	begin
		if (do_wr && wr_pal)
			palette[wr_idx] <= wmerge(palette[wr_idx], w_data, w_strb);
	end

	// config writes are accepted any time; changing them while enabled is software's risk
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_bpp <= FBP_RST_BPP;
			reg_swap <= FBP_RST_ZERO;
			reg_order <= FBP_RST_ZERO;
			reg_stride <= FBP_RST_ZERO;
			reg_enable <= FBP_RST_ZERO;
			reg_base <= FBP_RST_ZERO;
			reg_width <= FBP_RST_WIDTH;
			reg_height <= FBP_RST_HEIGHT;
		end
		else if (do_wr)
			case (aw_addr)
				FBP_OFS_BPP: reg_bpp <= wmerge(reg_bpp, w_data, w_strb);
				FBP_OFS_SWAP: reg_swap <= wmerge(reg_swap, w_data, w_strb);
				FBP_OFS_ORDER: reg_order <= wmerge(reg_order, w_data, w_strb);
				FBP_OFS_STRIDE: reg_stride <= wmerge(reg_stride, w_data, w_strb) & ~32'h0000_0003;
				FBP_OFS_ENABLE: reg_enable <= wmerge(reg_enable, w_data, w_strb) & 32'h0000_0001;
				FBP_OFS_BASE: reg_base <= wmerge(reg_base, w_data, w_strb) & ~32'h0000_0003;
				FBP_OFS_WIDTH: reg_width <= wmerge(reg_width, w_data, w_strb);
				FBP_OFS_HEIGHT: reg_height <= wmerge(reg_height, w_data, w_strb);
				default: reg_bpp <= reg_bpp;
			endcase
	end

	// fetch engine: one word in flight, issued only when the fifo has room
	wire [5:0] bits = cell_bits(reg_bpp);
	wire [DIM_W-1:0] width = reg_width[DIM_W-1:0];
	wire [DIM_W-1:0] height = reg_height[DIM_W-1:0];
	wire [DIM_W+5:0] row_bits = (DIM_W+6)'(width) * (DIM_W+6)'(bits);
	wire [DIM_W+1:0] row_words = (DIM_W+2)'(((DIM_W+7)'(row_bits) + (DIM_W+7)'(31)) >> 5);
	wire [31:0] stride = reg_stride == FBP_RST_ZERO ? {16'h0000, 14'(row_words), 2'b00} : reg_stride;
	logic [31:0] row_addr;
	logic [DIM_W+1:0] fetch_word;
	wire last_word = fetch_word == row_words - 1'b1;
	wire last_row = fetch_row == height - 1'b1;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_state <= FBP_F_IDLE;
			mem_req_valid <= 1'b0;
			mem_req_addr <= '0;
			row_addr <= '0;
			fetch_word <= '0;
			fetch_row <= '0;
		end
		else if (!enabled)
		begin
			fetch_state <= FBP_F_IDLE;
			mem_req_valid <= 1'b0;
			row_addr <= reg_base;
			fetch_word <= '0;
			fetch_row <= '0;
		end
		else
			case (fetch_state)
				FBP_F_IDLE:
					if (fifo_in_ready && width != '0 && height != '0)
					begin
						mem_req_valid <= 1'b1;
						mem_req_addr <= row_addr + {16'h0000, 14'(fetch_word), 2'b00};
						fetch_state <= FBP_F_REQ;
					end
				FBP_F_REQ:
					if (mem_req_ready)
					begin
						mem_req_valid <= 1'b0;
						fetch_state <= FBP_F_WAIT;
					end
				FBP_F_WAIT:
					if (mem_rsp_valid)
					begin
						fetch_state <= FBP_F_IDLE;
						fetch_word <= last_word ? '0 : fetch_word + 1'b1;
						if (last_word)
						begin
							fetch_row <= last_row ? '0 : fetch_row + 1'b1;
							row_addr <= last_row ? reg_base : row_addr + stride;
						end
					end
				default: fetch_state <= FBP_F_IDLE;
			endcase
	end

	wire [31:0] swapped = {fifo_out_data[7:0], fifo_out_data[15:8], fifo_out_data[23:16], fifo_out_data[31:24]};
	wire do_swap = reg_swap[0] && bits != 6'd24;
	wire [31:0] src_word = do_swap ? swapped : fifo_out_data;
	wire msb_first = reg_order[0] && bits < 6'd8;
	wire [31:0] packed_word = msb_first ? reorder(src_word, bits) : src_word;

	// bit queue: words enter above the bits still waiting, pixels leave from the bottom
	logic [63:0] bit_q;
	logic [6:0] bit_cnt;
	logic [DIM_W-1:0] col;
	logic [DIM_W-1:0] line;
	logic s1_valid;
	logic s1_pal;
	logic s1_eol;
	logic s1_eof;
	logic [31:0] s1_raw;
	logic [31:0] pal_q;
	wire have_pix = bit_cnt >= 7'(bits);
	assign fifo_out_ready = enabled && !have_pix;
	wire s2_free = !pix_valid || pix_ready;
	wire s1_load = enabled && have_pix && (!s1_valid || s2_free);
	wire [31:0] pix_mask = bits == 6'd32 ? 32'hffff_ffff : (32'h0000_0001 << bits) - 32'h0000_0001;
	wire [31:0] pix_raw = bit_q[31:0] & pix_mask;
	wire is_pal = bits <= 6'd8;
	wire eol = col == width - 1'b1;
	wire eof = eol && line == height - 1'b1;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_q <= '0;
			bit_cnt <= '0;
			col <= '0;
			line <= '0;
		end
		else if (!enabled)
		begin
			bit_q <= '0;
			bit_cnt <= '0;
			col <= '0;
			line <= '0;
		end
		else if (fifo_out_valid && fifo_out_ready)
		begin
			bit_q <= bit_q | ({32'h0000_0000, packed_word} << bit_cnt);
			bit_cnt <= bit_cnt + 7'd32;
		end
		else if (s1_load)
		begin
			// the row tail is padding up to the word boundary and is dropped
			bit_q <= eol ? '0 : bit_q >> bits;
			bit_cnt <= eol ? '0 : bit_cnt - 7'(bits);
			col <= eol ? '0 : col + 1'b1;
			if (eol)
				line <= eof ? '0 : line + 1'b1;
		end
	end

	// palette read is registered alongside the first pipeline stage
	always_ff @(posedge sys_clk)
	begin
		if (s1_load)
			pal_q <= palette[pix_raw[7:0]];
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_valid <= 1'b0;
			s1_pal <= 1'b0;
			s1_eol <= 1'b0;
			s1_eof <= 1'b0;
			s1_raw <= '0;
		end
		else if (!enabled)
			s1_valid <= 1'b0;
		else if (s1_load)
		begin
			s1_valid <= 1'b1;
			s1_pal <= is_pal;
			s1_eol <= eol;
			s1_eof <= eof;
			s1_raw <= pix_raw;
		end
		else if (s2_free)
			s1_valid <= 1'b0;
	end

	// direct colour: blue occupies the low bits; short channels are widened by a left shift
	logic [23:0] rgb;
	always_comb
	begin
		rgb = s1_raw[23:0];
		if (s1_pal)
			rgb = {pal_q[FBP_PAL_SEL -: 8], pal_q[FBP_GRN_LSB +: 8], pal_q[FBP_BLU_LSB +: 8]};
		else if (reg_bpp == 32'h0000_000f)
			rgb = {s1_raw[14:10], 3'b000, s1_raw[9:5], 3'b000, s1_raw[4:0], 3'b000};
		else if (bits == 6'd16)
			rgb = {s1_raw[15:11], 3'b000, s1_raw[10:5], 2'b00, s1_raw[4:0], 3'b000};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pix_valid <= 1'b0;
			pix_data <= '0;
		end
		else if (!enabled)
			pix_valid <= 1'b0;
		else if (s2_free)
		begin
			pix_valid <= s1_valid;
			if (s1_valid)
				pix_data <= '{eof: s1_eof, eol: s1_eol, rgb: rgb};
		end
	end

	fbp_fifo #(
		.WIDTH(32),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(!enabled),
		.in_valid(mem_rsp_valid && enabled),
		.in_data(mem_rsp_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_out_ready)
	);
endmodule : fbp_top

// file: verif/fbp_props.sv
// port checker for the pixel-format block: bus, fetch and pixel handshakes
`timescale 1ns/1ns
module fbp_props
	import fbp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mem_req_valid,
	input wire logic [31:0] mem_req_addr,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [31:0] mem_rsp_data,
	input wire logic pix_valid,
	input wire fbp_pix_s pix_data,
	input wire logic pix_ready
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer not two edges after handshake");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_req_align; mem_req_valid |-> mem_req_addr[1:0] == 2'h0; endproperty
	a_req_align: assert property (p_req_align) else $error("fetch not word aligned");
	property p_req_hold; mem_req_valid && !mem_req_ready |=> !mem_req_valid || $stable(mem_req_addr); endproperty
	a_req_hold: assert property (p_req_hold) else $error("fetch address moved while waiting");
	property p_rsp_gap; mem_rsp_valid |=> !mem_req_valid; endproperty
	a_rsp_gap: assert property (p_rsp_gap) else $error("fetch issued too soon after response");
	property p_pix_hold; pix_valid && !pix_ready |=> pix_valid && $stable(pix_data); endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel changed before taken");
endmodule : fbp_props

bind fbp_top fbp_props fbp_props_i (.*);

// file: verif/fbp_mem_model.sv
// source memory: answers one fetch at a time with an address-derived word
`timescale 1ns/1ns
module fbp_mem_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic mem_req_valid,
	input wire logic [31:0] mem_req_addr,
	output logic mem_req_ready,
	output logic mem_rsp_valid,
	output logic [31:0] mem_rsp_data,
	input int dly,
	output int n_taken
);
	logic pend;
	int cnt;
	logic [31:0] adr;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend <= 1'b0;
			cnt <= 0;
			adr <= 32'h0000_0000;
			mem_req_ready <= 1'b0;
			mem_rsp_valid <= 1'b0;
			mem_rsp_data <= 32'h0000_0000;
			n_taken <= 0;
		end
		else
		begin
			mem_rsp_valid <= 1'b0;
			// idle data keeps changing so a stale word is never mistaken for a fresh one
			mem_rsp_data <= ~mem_rsp_data;
			if (mem_req_valid && mem_req_ready)
			begin
				pend <= 1'b1;
				cnt <= dly;
				adr <= mem_req_addr;
				mem_req_ready <= 1'b0;
				n_taken <= n_taken + 1;
			end
			else if (pend && cnt == 0)
			begin
				pend <= 1'b0;
				mem_rsp_valid <= 1'b1;
				mem_rsp_data <= 32'h0403_0201 ^ {4{adr[7:0]}};
			end
			else if (pend)
				cnt <= cnt - 1;
			else
				mem_req_ready <= ~mem_req_ready | (dly == 0);
		end
	end
endmodule : fbp_mem_model

// file: verif/fbp_top_tb.sv
// bench: registers over axi4-lite, pixel stream checked against the memory model
`timescale 1ns/1ns
module fbp_top_tb;
	import fbp_pkg::*;
	logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pix_valid, pix_ready;
	logic mem_req_valid, mem_req_ready, mem_rsp_valid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_req_addr, mem_rsp_data, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	fbp_pix_s pix_data;
	int error_cnt, n_checks, dly, n_taken, c, i, j;
	logic [7:0] q;
	// bpp, swap, order, stride, width, height; strides stay multiples of four
	int cfg[10][6] = '{'{8, 0, 0, 32, 4, 2}, '{8, 1, 0, 0, 4, 2}, '{1, 0, 1, 32, 8, 2}, '{2, 1, 0, 32, 4, 2},
		'{2, 0, 1, 32, 4, 2}, '{4, 1, 1, 32, 2, 2}, '{15, 1, 1, 16, 2, 1}, '{16, 0, 1, 16, 2, 2},
		'{24, 1, 0, 16, 1, 2}, '{32, 1, 1, 8, 1, 2}};
	logic [11:0] offs[6] = '{FBP_OFS_BPP, FBP_OFS_SWAP, FBP_OFS_ORDER, FBP_OFS_STRIDE, FBP_OFS_WIDTH, FBP_OFS_HEIGHT};
	fbp_top fbp_top_i (.*);
	fbp_mem_model fbp_mem_model_i (.*);
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tmo;
		error_cnt++;
		$display("mismatch at %0t: wait ran out", $time);
		give_verdict();
	endtask : tmo
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (k == 50) tmo();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [11:0] a);
		int k;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (k == 50) tmo();
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr
	function automatic logic [23:0] expd(input int n, input int r, input int k);
		int b;
		logic [31:0] a, w, p;
		logic [7:0] m;
		b = cfg[n][0];
		a = 32'h0000_0100 + r * (cfg[n][3] != 0 ? cfg[n][3] : 4);
		w = 32'h0403_0201 ^ {4{a[7:0]}};
		if (cfg[n][1] != 0 && b != 24) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
		p = w >> (b < 8 ? (cfg[n][2] != 0 ? 8 - b - k * b : k * b) : k * (b == 8 ? 8 : 16));
		m = p[7:0] & 8'((1 << b) - 1);
		case (b)
			15: return {p[14:10], 3'h0, p[9:5], 3'h0, p[4:0], 3'h0};
			16: return {p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
			24, 32: return p[23:0];
			default: return {m, ~m, m ^ 8'h5a};
		endcase
	endfunction : expd
	task automatic frame(input int n);
		int r, k, t;
		fbp_pix_s e;
		r = 0;
		k = 0;
		for (t = 0; t < 4000 && r < cfg[n][5]; t++)
		begin
			@(posedge sys_clk);
			if ((pix_valid & pix_ready) === 1'b1)
			begin
				e.rgb = expd(n, r, k);
				e.eol = (k == cfg[n][4] - 1);
				e.eof = e.eol && (r == cfg[n][5] - 1);
				chk(32'(pix_data), 32'(e));
				k = e.eol ? 0 : k + 1;
				r = e.eol ? r + 1 : r;
			end
			// stalling every other cycle exercises the hold of pending pixels
			pix_ready <= ~pix_ready;
		end
		// sink stays ready from here, so a later disable never cuts a pixel that is still on offer
		@(posedge sys_clk);
		pix_ready <= 1'b1;
		if (r < cfg[n][5]) tmo();
	endtask : frame
	initial
	begin
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pix_ready} = 6'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		dly = 0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (i = 0; i < 3; i++)
		begin
			rdr(FBP_OFS_ORDER + 12'(4 * i));
			chk(rd, FBP_RST_ZERO);
		end
		rdr(12'h100);
		chk({30'h0, rs}, {30'h0, FBP_RESP_SLVERR});
		chk(rd, 32'h0000_0000);
		wr(12'h100, 32'h0000_0001);
		chk({30'h0, rs}, {30'h0, FBP_RESP_SLVERR});
		for (i = 0; i < 256; i++)
		begin
			q = 8'(i);
			wr(FBP_OFS_PAL_LO + 12'(4 * i), {8'haa, q, ~q, q ^ 8'h5a});
			chk({30'h0, rs}, {30'h0, FBP_RESP_OKAY});
		end
		rdr(FBP_OFS_PAL_HI);
		chk(rd, 32'haaff_00a5);
		wr(FBP_OFS_BASE, 32'h0000_0100);
		for (c = 0; c < 10; c++)
		begin
			dly <= (c % 3) * 3;
			for (j = 0; j < 6; j++) wr(offs[j], 32'(cfg[c][j]));
			wr(FBP_OFS_ENABLE, 32'h0000_0001);
			if (c == 0)
			begin
				// with the sink stalled the fifo fills and fetching must stop
				repeat (150) @(posedge sys_clk);
				i = n_taken;
				repeat (20) @(posedge sys_clk);
				chk(32'(n_taken), 32'(i));
				// eight fifo words plus the one parked in the bit queue
				chk(32'(i), 32'h0000_0009);
			end
			frame(c);
			wr(FBP_OFS_ENABLE, 32'h0000_0000);
			for (i = 0; i < 20; i++)
			begin
				@(posedge sys_clk);
				chk({31'h0, mem_req_valid | pix_valid}, 32'h0000_0000);
			end
		end
		give_verdict();
	end
endmodule : fbp_top_tb
